// *** fdd_defines.vh ***
// constants of the drive fault detection block
// assumes a 250 MHz core clock and a 32-bit word register port
`ifndef FDD_DEFINES_VH
`define FDD_DEFINES_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define FDD_OFS_FAULT    8'h00
`define FDD_OFS_CODE     8'h04
`define FDD_OFS_STATUS   8'h08
`define FDD_OFS_PREOVL   8'h0C
`define FDD_OFS_PLEVEL   8'h10
`define FDD_OFS_PTIME    8'h14
`define FDD_OFS_SPECIAL  8'h18
`define FDD_OFS_FCLLIM   8'h1C
`define FDD_OFS_PASSWORD 8'h20

// ****************************************
// fault bit positions
// ****************************************
`define FDD_F_BUS     0
`define FDD_F_SDO     1
`define FDD_F_PDO     2
`define FDD_F_INDEX   3
`define FDD_F_SUBIDX  4
`define FDD_F_SIZE    5
`define FDD_F_RANGE   6
`define FDD_F_RDONLY  7
`define FDD_F_MAP     8
`define FDD_F_LOCK    9
`define FDD_F_LOAD    10
`define FDD_F_STORE   11
`define FDD_F_ADDR    12
`define FDD_F_CSUM    13
`define FDD_F_PWD     14
`define FDD_F_ENC     15
`define FDD_F_MPROT   16
`define FDD_F_FCL     17
`define FDD_F_FWUP    18
`define FDD_NFAULT    19

// ****************************************
// status bit positions
// ****************************************
`define FDD_S_WARN    0
`define FDD_S_UNLOCK  1
`define FDD_S_EERST   2

// ****************************************
// reset values and thresholds
// ****************************************
`define FDD_RST_PREOVL  16'h0000
`define FDD_RST_PLEVEL  16'h0000
`define FDD_RST_PTIME   16'h0000
`define FDD_RST_SPECIAL 16'h0000
`define FDD_RST_FCLLIM  32'h00000000
`define FDD_ERRCNT_LIM  8'h80
`define FDD_ENC_LIMIT   2'h3
`define FDD_SF_FIRST    16'h001E
`define FDD_SF_SECOND   16'h001C

// ****************************************
// timing
// ****************************************
`define FDD_CLK_NS      4
`define FDD_WINDOW_NS   1000000
`define FDD_MS_CYCLES   (`FDD_WINDOW_NS / `FDD_CLK_NS)

`endif

// *** fdd_sticky.v ***
// sticky flag bank: a set in the cycle of its clear wins
// assumes set and clear are synchronous one-bit-per-flag vectors
module fdd_sticky #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rstn_i,
  input  wire [W-1:0] set_i,
  input  wire [W-1:0] clr_i,
  output reg  [W-1:0] q_o
);

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_o <= {W{1'b0}};
    end else begin
      q_o <= (q_o & ~clr_i) | set_i;
    end
  end

endmodule

// *** fdd_persist.v ***
// persistence timer: reached once cond has held for limit ticks
// assumes tick_i is a one-cycle pulse; a drop of cond restarts the count
module fdd_persist #(
  parameter W = 16
) (
  input  wire         clk_i,
  input  wire         rstn_i,
  input  wire         cond_i,
  input  wire         tick_i,
  input  wire [W-1:0] limit_i,
  output reg          reached_o
);

  reg [W-1:0] cnt;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt       <= {W{1'b0}};
      reached_o <= 1'b0;
    end else if (!cond_i) begin
      cnt       <= {W{1'b0}};
      reached_o <= 1'b0;
    end else begin
      if (tick_i && cnt != limit_i) begin
        cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
      end
      reached_o <= (cnt == limit_i);
    end
  end

endmodule

// *** fdd_top.v ***
// drive fault detection: latches link, object access, store and motion faults
// assumes object dictionary lookups and store results arrive as flags
// beside one-cycle strobes, all synchronous to CLK_I
//
// Overview of operation
// RQ1: bus fault on bus-off or either error counter above 128.
// RQ2: SDO overrun fault on two SDO frames within one 1 ms window.
// RQ3: PDO overrun fault on two same-COB-ID PDO frames in one window.
// RQ4: PDO access to a missing index is refused with index fault.
// RQ5: PDO access to a missing sub-index is refused with sub-index fault.
// RQ6: PDO length unequal to object size is refused with size fault.
// RQ7: PDO write value outside object range is refused with range fault.
// RQ8: PDO write to a read-only object is refused with read-only fault.
// RQ9: PDO access to an unmappable object gives a mapping fault.
// RQ10: writes to servo-on locked objects are refused while servo on.
// RQ11: failed start-up load raises load fault and restores object defaults.
// RQ12: failed store of settings raises store fault.
// RQ13: stored data beyond allotted space raises address range fault.
// RQ14: stored checksum mismatch raises checksum fault and restores defaults.
// RQ15: password-protected access refused until the right password is given.
// RQ16: encoder data fault only on the third encoder data error.
// RQ17: motor protection alarm after level held for the protection time.
// RQ18: overload warning output when load reaches pre-overload threshold.
// RQ19: writing 30 then 28 to special function clears upgrade fault on restart.
// RQ20: full closed-loop deviation fault when deviation exceeds its limit.
// RQ21: every fault is latched and readable until its clearing action.
`include "fdd_defines.vh"

module fdd_top #(
  parameter [31:0] MS_CYCLES = `FDD_MS_CYCLES,
  parameter        NSLOT     = 4,
  parameter [31:0] PASSKEY   = 32'h5A5A0001
) (
  input  wire        CLK_I,
  input  wire        RSTN_I,
  input  wire [7:0]  ADDR_I,
  input  wire [31:0] WDATA_I,
  input  wire        WR_I,
  input  wire        RD_I,
  output reg  [31:0] RDATA_O,
  input  wire        BUS_OFF_I,
  input  wire [7:0]  RX_ERR_CNT_I,
  input  wire [7:0]  TX_ERR_CNT_I,
  input  wire        SDO_RX_I,
  input  wire        PDO_RX_I,
  input  wire [10:0] PDO_COBID_I,
  input  wire        PDO_ACC_I,
  input  wire        PDO_WRITE_I,
  input  wire        OBJ_IDX_OK_I,
  input  wire        OBJ_SUB_OK_I,
  input  wire        OBJ_PDO_OK_I,
  input  wire [3:0]  OBJ_SIZE_I,
  input  wire [3:0]  PDO_LEN_I,
  input  wire        OBJ_RDONLY_I,
  input  wire        OBJ_SRVLOCK_I,
  input  wire        OBJ_PWD_I,
  input  wire [31:0] PDO_VALUE_I,
  input  wire [31:0] OBJ_MIN_I,
  input  wire [31:0] OBJ_MAX_I,
  input  wire        SERVO_ON_I,
  input  wire        NV_LOAD_DONE_I,
  input  wire        NV_LOAD_FAIL_I,
  input  wire        NV_RANGE_FAIL_I,
  input  wire        NV_CSUM_FAIL_I,
  input  wire        NV_STORE_DONE_I,
  input  wire        NV_STORE_FAIL_I,
  input  wire        FW_STALE_I,
  input  wire        ENC_ERR_I,
  input  wire [15:0] LOAD_LEVEL_I,
  input  wire        FCL_MODE_I,
  input  wire [31:0] FCL_DEV_I,
  output reg         PDO_DONE_O,
  output reg         PDO_REJECT_O,
  output reg         DEFAULTS_RESTORE_O,
  output reg         EE_RESET_REQ_O,
  output reg         OVERLOAD_WARNING_O,
  output reg         OVERLOAD_ALARM_O,
  output wire        FAULT_O
);

  localparam PW = (NSLOT > 1) ? $clog2(NSLOT) : 1;
  localparam NF = `FDD_NFAULT;

  // ****************************************
  // register port
  // ****************************************
  reg  [15:0]   preoverload_threshold_param;
  reg  [15:0]   motor_protect_level_param;
  reg  [15:0]   motor_protect_time_param;
  reg  [15:0]   special_function_param;
  reg  [31:0]   fcl_limit;
  reg           unlocked;
  reg           sf_armed;
  reg  [4:0]    fault_code;
  wire [NF-1:0] fault;
  reg  [NF-1:0] fault_set;
  wire [NF-1:0] fault_clr;
  wire          wr_fault;
  wire          wr_special;

  assign wr_fault   = WR_I && (ADDR_I == `FDD_OFS_FAULT);
  assign wr_special = WR_I && (ADDR_I == `FDD_OFS_SPECIAL);

  // write-one-to-clear; the upgrade fault ignores it and leaves only by restart
  assign fault_clr = wr_fault ? (WDATA_I[NF-1:0] & ~({{(NF-1){1'b0}}, 1'b1} << `FDD_F_FWUP))
                              : {NF{1'b0}}; // [RQ21] [RQ19]

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      preoverload_threshold_param <= `FDD_RST_PREOVL;
      motor_protect_level_param   <= `FDD_RST_PLEVEL;
      motor_protect_time_param    <= `FDD_RST_PTIME;
      special_function_param      <= `FDD_RST_SPECIAL;
      fcl_limit                   <= `FDD_RST_FCLLIM;
      unlocked                    <= 1'b0;
    end else if (WR_I) begin
      case (ADDR_I)
        `FDD_OFS_PREOVL:   preoverload_threshold_param <= WDATA_I[15:0];
        `FDD_OFS_PLEVEL:   motor_protect_level_param   <= WDATA_I[15:0];
        `FDD_OFS_PTIME:    motor_protect_time_param    <= WDATA_I[15:0];
        `FDD_OFS_SPECIAL:  special_function_param      <= WDATA_I[15:0];
        `FDD_OFS_FCLLIM:   fcl_limit                   <= WDATA_I;
        `FDD_OFS_PASSWORD: unlocked <= (WDATA_I == PASSKEY); // [RQ15]
        default: begin
        end
      endcase
    end
  end

  // 30 arms the sequence, 28 right after it requests the store reset
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sf_armed       <= 1'b0;
      EE_RESET_REQ_O <= 1'b0;
    end else if (wr_special) begin
      if (WDATA_I[15:0] == `FDD_SF_FIRST) begin
        sf_armed <= 1'b1; // [RQ19]
      end else if (sf_armed && WDATA_I[15:0] == `FDD_SF_SECOND) begin
        sf_armed       <= 1'b0;
        EE_RESET_REQ_O <= 1'b1; // [RQ19]
      end else begin
        sf_armed <= 1'b0;
      end
    end
  end

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RDATA_O <= 32'h00000000;
    end else if (RD_I) begin
      case (ADDR_I)
        `FDD_OFS_FAULT:    RDATA_O <= {{(32-NF){1'b0}}, fault}; // [RQ21]
        `FDD_OFS_CODE:     RDATA_O <= {27'h0000000, fault_code};
        `FDD_OFS_STATUS:   RDATA_O <= {29'h00000000, EE_RESET_REQ_O, unlocked, OVERLOAD_WARNING_O};
        `FDD_OFS_PREOVL:   RDATA_O <= {16'h0000, preoverload_threshold_param};
        `FDD_OFS_PLEVEL:   RDATA_O <= {16'h0000, motor_protect_level_param};
        `FDD_OFS_PTIME:    RDATA_O <= {16'h0000, motor_protect_time_param};
        `FDD_OFS_SPECIAL:  RDATA_O <= {16'h0000, special_function_param};
        `FDD_OFS_FCLLIM:   RDATA_O <= fcl_limit;
        default:           RDATA_O <= 32'h00000000;
      endcase
    end else begin
      RDATA_O <= 32'h00000000;
    end
  end

  // ****************************************
  // 1 ms window and receive overruns
  // ****************************************
  reg  [31:0]      ms_cnt;
  wire             ms_tick;
  reg              sdo_seen;
  reg  [10:0]      slot_id [0:NSLOT-1];
  reg  [NSLOT-1:0] slot_v;
  reg  [PW-1:0]    slot_ptr;
  wire [NSLOT-1:0] slot_hit;
  wire             pdo_dup;
  integer          i;

  // windows are fixed, so two frames straddling a boundary are not an overrun
  assign ms_tick = (ms_cnt == MS_CYCLES - 32'h00000001);

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ms_cnt <= 32'h00000000;
    end else begin
      ms_cnt <= ms_tick ? 32'h00000000 : ms_cnt + 32'h00000001;
    end
  end

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sdo_seen <= 1'b0;
    end else begin
      sdo_seen <= ms_tick ? 1'b0 : (sdo_seen | SDO_RX_I); // [RQ2]
    end
  end

  genvar g;
  generate
    for (g = 0; g < NSLOT; g = g + 1) begin : g_slot
      assign slot_hit[g] = slot_v[g] && (slot_id[g] == PDO_COBID_I);
    end
  endgenerate

  assign pdo_dup = PDO_RX_I && (|slot_hit); // [RQ3]

  // only NSLOT distinct COB-IDs are tracked per window; the oldest is overwritten
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      slot_v   <= {NSLOT{1'b0}};
      slot_ptr <= {PW{1'b0}};
      for (i = 0; i < NSLOT; i = i + 1) begin
        slot_id[i] <= 11'h000;
      end
    end else if (ms_tick) begin
      slot_v   <= {NSLOT{1'b0}};
      slot_ptr <= {PW{1'b0}};
    end else if (PDO_RX_I && !pdo_dup) begin
      slot_id[slot_ptr] <= PDO_COBID_I;
      slot_v[slot_ptr]  <= 1'b1;
      slot_ptr <= (slot_ptr == NSLOT - 1) ? {PW{1'b0}} : slot_ptr + {{(PW-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // PDO object access check
  // ****************************************
  reg [NF-1:0] acc_err;

  // first failing check wins, so one access raises one fault
  always @* begin
    acc_err = {NF{1'b0}};
    if (!OBJ_IDX_OK_I) begin
      acc_err[`FDD_F_INDEX] = 1'b1; // [RQ4]
    end else if (!OBJ_SUB_OK_I) begin
      acc_err[`FDD_F_SUBIDX] = 1'b1; // [RQ5]
    end else if (!OBJ_PDO_OK_I) begin
      acc_err[`FDD_F_MAP] = 1'b1; // [RQ9]
    end else if (PDO_LEN_I != OBJ_SIZE_I) begin
      acc_err[`FDD_F_SIZE] = 1'b1; // [RQ6]
    end else if (OBJ_PWD_I && !unlocked) begin
      acc_err[`FDD_F_PWD] = 1'b1; // [RQ15]
    end else if (PDO_WRITE_I && OBJ_RDONLY_I) begin
      acc_err[`FDD_F_RDONLY] = 1'b1; // [RQ8]
    end else if (PDO_WRITE_I && OBJ_SRVLOCK_I && SERVO_ON_I) begin
      acc_err[`FDD_F_LOCK] = 1'b1; // [RQ10]
    end else if (PDO_WRITE_I && (PDO_VALUE_I < OBJ_MIN_I || PDO_VALUE_I > OBJ_MAX_I)) begin
      acc_err[`FDD_F_RANGE] = 1'b1; // [RQ7]
    end
  end

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PDO_DONE_O   <= 1'b0;
      PDO_REJECT_O <= 1'b0;
    end else begin
      PDO_DONE_O   <= PDO_ACC_I;
      PDO_REJECT_O <= PDO_ACC_I && (|acc_err); // [RQ4] [RQ5] [RQ6] [RQ7] [RQ8] [RQ10] [RQ15]
    end
  end

  // ****************************************
  // encoder, motor protection, overload
  // ****************************************
  reg  [1:0] enc_cnt;
  wire       enc_third;
  wire       mprot_hit;

  assign enc_third = ENC_ERR_I && (enc_cnt == `FDD_ENC_LIMIT - 2'h1); // [RQ16]

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      enc_cnt <= 2'h0;
    end else if (fault_clr[`FDD_F_ENC] && !ENC_ERR_I) begin
      enc_cnt <= 2'h0;
    end else if (ENC_ERR_I && enc_cnt != `FDD_ENC_LIMIT) begin
      enc_cnt <= enc_cnt + 2'h1; // [RQ16]
    end
  end

  fdd_persist #(
    .W (16)
  ) u_mprot (
    .clk_i     (CLK_I),
    .rstn_i    (RSTN_I),
    .cond_i    (LOAD_LEVEL_I >= motor_protect_level_param),
    .tick_i    (ms_tick),
    .limit_i   (motor_protect_time_param),
    .reached_o (mprot_hit)
  ); // [RQ17]

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      OVERLOAD_WARNING_O <= 1'b0;
      OVERLOAD_ALARM_O   <= 1'b0;
    end else begin
      OVERLOAD_WARNING_O <= (LOAD_LEVEL_I >= preoverload_threshold_param); // [RQ18]
      OVERLOAD_ALARM_O   <= fault[`FDD_F_MPROT]; // [RQ17]
    end
  end

  // ****************************************
  // fault latching and code
  // ****************************************
  always @* begin
    fault_set = {NF{1'b0}};
    fault_set[`FDD_F_BUS] = BUS_OFF_I || (RX_ERR_CNT_I > `FDD_ERRCNT_LIM)
                            || (TX_ERR_CNT_I > `FDD_ERRCNT_LIM); // [RQ1]
    fault_set[`FDD_F_SDO] = SDO_RX_I && sdo_seen && !ms_tick; // [RQ2]
    fault_set[`FDD_F_PDO] = pdo_dup && !ms_tick; // [RQ3]
    if (PDO_ACC_I) begin
      fault_set = fault_set | acc_err; // [RQ9]
    end
    fault_set[`FDD_F_LOAD]  = NV_LOAD_DONE_I && NV_LOAD_FAIL_I; // [RQ11]
    fault_set[`FDD_F_ADDR]  = NV_LOAD_DONE_I && NV_RANGE_FAIL_I; // [RQ13]
    fault_set[`FDD_F_CSUM]  = NV_LOAD_DONE_I && NV_CSUM_FAIL_I; // [RQ14]
    fault_set[`FDD_F_STORE] = NV_STORE_DONE_I && NV_STORE_FAIL_I; // [RQ12]
    fault_set[`FDD_F_ENC]   = enc_third;
    fault_set[`FDD_F_MPROT] = mprot_hit;
    fault_set[`FDD_F_FCL]   = FCL_MODE_I && (FCL_DEV_I > fcl_limit); // [RQ20]
    fault_set[`FDD_F_FWUP]  = FW_STALE_I; // [RQ19]
  end

  fdd_sticky #(
    .W (NF)
  ) u_fault (
    .clk_i  (CLK_I),
    .rstn_i (RSTN_I),
    .set_i  (fault_set),
    .clr_i  (fault_clr),
    .q_o    (fault)
  ); // [RQ21]

  assign FAULT_O = |fault;

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      DEFAULTS_RESTORE_O <= 1'b0;
    end else begin
      DEFAULTS_RESTORE_O <= NV_LOAD_DONE_I && (NV_LOAD_FAIL_I || NV_CSUM_FAIL_I); // [RQ11] [RQ14]
    end
  end

  // code is the lowest newly set bit plus one; zero once all faults are gone
  reg [4:0] next_code;
  integer   k;

  always @* begin
    next_code = fault_code;
    if (((fault & ~fault_clr) | fault_set) == {NF{1'b0}}) begin
      next_code = 5'h00;
    end
    for (k = NF - 1; k >= 0; k = k - 1) begin
      if (fault_set[k] && !fault[k]) begin
        next_code = k[4:0] + 5'h01;
      end
    end
  end

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      fault_code <= 5'h00;
    end else begin
      fault_code <= next_code; // [RQ21]
    end
  end

endmodule

// *** fdd_properties.sv ***
// port assertions for the drive fault detection block
// assumes one clock domain with an async active-low reset
module fdd_props (
  input logic        CLK_I,
  input logic        RSTN_I,
  input logic [7:0]  ADDR_I,
  input logic [31:0] WDATA_I,
  input logic        WR_I,
  input logic        BUS_OFF_I,
  input logic [7:0]  RX_ERR_CNT_I,
  input logic [7:0]  TX_ERR_CNT_I,
  input logic        PDO_ACC_I,
  input logic        PDO_WRITE_I,
  input logic        OBJ_IDX_OK_I,
  input logic        OBJ_SUB_OK_I,
  input logic        OBJ_PDO_OK_I,
  input logic [3:0]  OBJ_SIZE_I,
  input logic [3:0]  PDO_LEN_I,
  input logic        OBJ_RDONLY_I,
  input logic        NV_LOAD_DONE_I,
  input logic        NV_LOAD_FAIL_I,
  input logic        NV_CSUM_FAIL_I,
  input logic        PDO_DONE_O,
  input logic        PDO_REJECT_O,
  input logic        DEFAULTS_RESTORE_O,
  input logic        EE_RESET_REQ_O,
  input logic        FAULT_O
);
  // ****************************************
  // sequences and properties
  // ****************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence sf_first;
    WR_I && ADDR_I == 8'h18 && WDATA_I == 32'h0000001E;
  endsequence
  sequence sf_second;
    WR_I && ADDR_I == 8'h18 && WDATA_I == 32'h0000001C;
  endsequence
  sequence sf_unlock;
    sf_first ##1 !WR_I ##1 sf_second;
  endsequence
  AST_BUS: assert property (BUS_OFF_I || RX_ERR_CNT_I > 8'h80 || TX_ERR_CNT_I > 8'h80 |=> FAULT_O)
    else $error("bus fault not raised");
  AST_LOOKUP: assert property (PDO_ACC_I && !(OBJ_IDX_OK_I && OBJ_SUB_OK_I && OBJ_PDO_OK_I) |=> PDO_REJECT_O)
    else $error("bad object lookup accepted");
  AST_SIZE: assert property (PDO_ACC_I && PDO_LEN_I != OBJ_SIZE_I |=> PDO_DONE_O && PDO_REJECT_O)
    else $error("length mismatch accepted");
  AST_RDONLY: assert property (PDO_ACC_I && PDO_WRITE_I && OBJ_RDONLY_I |=> PDO_REJECT_O)
    else $error("read-only write accepted");
  AST_DONE: assert property (PDO_DONE_O |-> $past(PDO_ACC_I))
    else $error("done without access");
  AST_RESTORE: assert property (NV_LOAD_DONE_I && (NV_LOAD_FAIL_I || NV_CSUM_FAIL_I) |=> DEFAULTS_RESTORE_O)
    else $error("defaults not restored");
  AST_SFSEQ: assert property (sf_unlock |=> EE_RESET_REQ_O [*2])
    else $error("store reset request missing");
  AST_STICKY: assert property (FAULT_O && !(WR_I && ADDR_I == 8'h00) |=> FAULT_O)
    else $error("fault dropped without clear");
endmodule

bind fdd_top fdd_props chk_u (.CLK_I, .RSTN_I, .ADDR_I, .WDATA_I, .WR_I, .BUS_OFF_I, .RX_ERR_CNT_I, .TX_ERR_CNT_I,
  .PDO_ACC_I, .PDO_WRITE_I, .OBJ_IDX_OK_I, .OBJ_SUB_OK_I, .OBJ_PDO_OK_I, .OBJ_SIZE_I, .PDO_LEN_I, .OBJ_RDONLY_I,
  .NV_LOAD_DONE_I, .NV_LOAD_FAIL_I, .NV_CSUM_FAIL_I, .PDO_DONE_O, .PDO_REJECT_O, .DEFAULTS_RESTORE_O,
  .EE_RESET_REQ_O, .FAULT_O);

// *** fdd_master.sv ***
// network master model: sends one SDO or PDO frame per request
// assumes requests are at least four cycles apart
module fdd_master (
  input  logic        clk_i,
  input  logic        rstn_i,
  input  logic        req_i,
  input  logic        pdo_i,
  input  logic [10:0] cobid_i,
  input  logic [3:0]  delay_i,
  output logic        sdo_rx_o,
  output logic        pdo_rx_o,
  output logic [10:0] cobid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  cnt;
  logic        pend;
  logic        kind;
  logic [10:0] id;
  // ****************************************
  // frame timing
  // ****************************************
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend <= 1'b0;
      cnt <= 4'h0;
      kind <= 1'b0;
      id <= 11'h000;
      sdo_rx_o <= 1'b0;
      pdo_rx_o <= 1'b0;
      cobid_o <= 11'h000;
    end else begin
      sdo_rx_o <= 1'b0;
      pdo_rx_o <= 1'b0;
      // id lines toggle between frames, alternating the last id and its inverse
      cobid_o <= ~cobid_o;
      if (req_i) begin
        pend <= 1'b1;
        cnt <= delay_i;
        kind <= pdo_i;
        id <= cobid_i;
      end else if (pend && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (pend) begin
        pend <= 1'b0;
        sdo_rx_o <= !kind;
        pdo_rx_o <= kind;
        cobid_o <= id;
      end
    end
  end
endmodule

// *** fdd_tb.sv ***
// self-checking bench for the drive fault detection block
// assumes a 4 ns clock and a one-cycle read latency
`include "fdd_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // short window keeps overrun and protection timing cheap
  localparam int MS = 50;
  localparam logic [31:0] KEY = 32'h13572468;
  localparam logic [7:0] FA = `FDD_OFS_FAULT;
  localparam logic [7:0] ST = `FDD_OFS_STATUS;
  logic CLK_I = 0, RSTN_I = 0, wr_s = 0, rd_s = 0, rq = 0, rpdo = 0, rd_d = 0;
  logic [7:0] adr = 0, rxe = 0, txe = 0;
  logic [31:0] wd = 0, rdat, val = 0, dev = 0;
  logic [15:0] load = 0;
  logic [10:0] rid = 0, cob;
  logic [3:0] len = 4, dly = 0;
  logic bof = 0, acc = 0, wrt = 0, iok = 1, sok = 1, pok = 1, ro = 0, lk = 0, pw = 0, son = 0;
  logic ld = 0, lf = 0, rf = 0, cf = 0, sd = 0, sf = 0, fws = 0, enc = 0, fcl = 0, sdo, pdo, done, rej, alm, flt;
  logic [31:0] qm[$], qe[$];
  logic qr[$];
  int fails = 0, cmp_count = 0, cyc = 0, k;
  int fb[8] = '{`FDD_F_INDEX, `FDD_F_SUBIDX, `FDD_F_MAP, `FDD_F_SIZE, `FDD_F_PWD, `FDD_F_RDONLY, `FDD_F_LOCK, `FDD_F_RANGE};
  int nvb[4] = '{`FDD_F_LOAD, `FDD_F_ADDR, `FDD_F_CSUM, `FDD_F_STORE};

  fdd_top #(.MS_CYCLES(MS), .PASSKEY(KEY)) dut_u (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(adr), .WDATA_I(wd),
    .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdat), .BUS_OFF_I(bof), .RX_ERR_CNT_I(rxe), .TX_ERR_CNT_I(txe),
    .SDO_RX_I(sdo), .PDO_RX_I(pdo), .PDO_COBID_I(cob), .PDO_ACC_I(acc), .PDO_WRITE_I(wrt), .OBJ_IDX_OK_I(iok),
    .OBJ_SUB_OK_I(sok), .OBJ_PDO_OK_I(pok), .OBJ_SIZE_I(4'h4), .PDO_LEN_I(len), .OBJ_RDONLY_I(ro),
    .OBJ_SRVLOCK_I(lk), .OBJ_PWD_I(pw), .PDO_VALUE_I(val), .OBJ_MIN_I(32'h0000000A), .OBJ_MAX_I(32'h00000064),
    .SERVO_ON_I(son), .NV_LOAD_DONE_I(ld), .NV_LOAD_FAIL_I(lf), .NV_RANGE_FAIL_I(rf), .NV_CSUM_FAIL_I(cf),
    .NV_STORE_DONE_I(sd), .NV_STORE_FAIL_I(sf), .FW_STALE_I(fws), .ENC_ERR_I(enc), .LOAD_LEVEL_I(load),
    .FCL_MODE_I(fcl), .FCL_DEV_I(dev), .PDO_DONE_O(done), .PDO_REJECT_O(rej), .DEFAULTS_RESTORE_O(),
    .EE_RESET_REQ_O(), .OVERLOAD_WARNING_O(), .OVERLOAD_ALARM_O(alm), .FAULT_O(flt));
  fdd_master fm_u (.clk_i(CLK_I), .rstn_i(RSTN_I), .req_i(rq), .pdo_i(rpdo), .cobid_i(rid), .delay_i(dly),
    .sdo_rx_o(sdo), .pdo_rx_o(pdo), .cobid_o(cob));

  // ****************************************
  // clock, phase count and result checking
  // ****************************************
  always #2 CLK_I = ~CLK_I;
  always @(posedge CLK_I) cyc <= RSTN_I ? cyc + 1 : 0;

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge CLK_I) begin
    rd_d <= rd_s;
    if (rd_d && qm.size() > 0) check(rdat & qm.pop_front(), qe.pop_front());
    if (done && qr.size() > 0) check(rej, qr.pop_front());
  end

  initial begin
    #300000;
    fails++;
    complete_run;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    wr_s <= 1;
    adr <= a;
    wd <= d;
    @(posedge CLK_I);
    wr_s <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge CLK_I);
    rd_s <= 1;
    adr <= a;
    qm.push_back(m);
    qe.push_back(e);
    @(posedge CLK_I);
    rd_s <= 0;
  endtask

  task automatic probe(input int b, input logic e);
    rd(FA, 1 << b, e ? 1 << b : 0);
    wr(FA, 1 << b);
  endtask

  task automatic at_phase;
    for (int i = 0; i < 2 * MS && cyc % MS != 20; i++) @(posedge CLK_I);
    check(cyc % MS, 20);
  endtask

  task automatic frame(input logic p, input logic [10:0] id);
    @(posedge CLK_I);
    rq <= 1;
    rpdo <= p;
    rid <= id;
    dly <= $urandom_range(2, 0);
    @(posedge CLK_I);
    rq <= 0;
    repeat (3) @(posedge CLK_I);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hF4AF));
    repeat (2) @(posedge CLK_I);
    RSTN_I <= 1;
    rd(`FDD_OFS_PTIME, 32'h0000FFFF, 0);
    wr(`FDD_OFS_PLEVEL, 32'h0000FFFF);
    wr(`FDD_OFS_PREOVL, 32'h0000FFFF);
    wr(`FDD_OFS_FCLLIM, 32'h000003E8);
    wr(FA, 32'h0007FFFF);
    rd(FA, 32'h0007FFFF, 0);
    check(flt, 0);
    // lookups in priority order, then accepted corner cases
    for (k = 0; k < 11; k++) begin
      if (k == 10) wr(8'h20, KEY);
      @(posedge CLK_I);
      acc <= 1;
      wrt <= k != 8;
      son <= k != 9;
      iok <= k != 0;
      sok <= k != 1;
      pok <= k != 2;
      len <= k == 3 ? 4'h2 : 4'h4;
      pw <= k == 4 || k == 10;
      ro <= k == 5;
      lk <= k == 6 || k == 9;
      val <= (k == 7 || k == 8) ? $urandom_range(9000, 101) : $urandom_range(100, 10);
      qr.push_back(k < 8);
      @(posedge CLK_I);
      acc <= 0;
      rd(FA, 32'h0007FFFF, k < 8 ? 1 << fb[k % 8] : 0);
      if (k < 8) rd(`FDD_OFS_CODE, 32'h1F, fb[k % 8] + 1);
      wr(FA, 32'h0007FFFF);
    end
    rd(ST, 32'h2, 32'h2);
    wr(8'h20, ~KEY);
    rd(ST, 32'h2, 0);
    for (k = 0; k < 4; k++) begin
      @(posedge CLK_I);
      bof <= k == 0;
      rxe <= k == 1 ? 8'h81 : k == 2 ? 8'h80 : 8'h00;
      txe <= k == 3 ? 8'h81 : 8'h00;
      @(posedge CLK_I);
      bof <= 0;
      rxe <= 0;
      txe <= 0;
      probe(`FDD_F_BUS, k != 2);
    end
    for (k = 0; k < 4; k++) begin
      @(posedge CLK_I);
      ld <= k < 3;
      lf <= k == 0;
      rf <= k == 1;
      cf <= k == 2;
      sd <= k == 3;
      sf <= k == 3;
      @(posedge CLK_I);
      ld <= 0;
      sd <= 0;
      probe(nvb[k], 1);
    end
    // same window, split windows, same id, different ids
    for (k = 0; k < 4; k++) begin
      at_phase;
      frame(k > 1, 11'h0A5);
      if (k == 1) at_phase;
      frame(k > 1, k == 3 ? 11'h0A6 : 11'h0A5);
      repeat (4) @(posedge CLK_I);
      probe(k > 1 ? `FDD_F_PDO : `FDD_F_SDO, k % 2 == 0);
    end
    for (k = 1; k < 5; k++) begin
      @(posedge CLK_I);
      enc <= 1;
      @(posedge CLK_I);
      enc <= 0;
      rd(FA, 1 << `FDD_F_ENC, k == 3 ? 1 << `FDD_F_ENC : 0);
      if (k == 3) wr(FA, 1 << `FDD_F_ENC);
    end
    load <= 16'h0096;
    wr(`FDD_OFS_PREOVL, 32'h00000078);
    rd(ST, 32'h1, 32'h1);
    wr(`FDD_OFS_PREOVL, 32'h000000C8);
    rd(ST, 32'h1, 0);
    wr(`FDD_OFS_PTIME, 32'h2);
    wr(`FDD_OFS_PLEVEL, 32'h00000064);
    repeat (30) @(posedge CLK_I);
    rd(FA, 1 << `FDD_F_MPROT, 0);
    check(alm, 0);
    repeat (120) @(posedge CLK_I);
    check(alm, 1);
    check(flt, 1);
    wr(`FDD_OFS_PLEVEL, 32'h0000FFFF);
    probe(`FDD_F_MPROT, 1);
    fcl <= 1;
    for (k = 0; k < 2; k++) begin
      @(posedge CLK_I);
      dev <= k ? 32'h000003E9 : 32'h000003E8;
      repeat (2) @(posedge CLK_I);
      dev <= 0;
      probe(`FDD_F_FCL, k);
    end
    wr(`FDD_OFS_SPECIAL, 32'h1E);
    wr(`FDD_OFS_SPECIAL, 32'h05);
    wr(`FDD_OFS_SPECIAL, 32'h1C);
    rd(ST, 32'h4, 0);
    fws <= 1;
    wr(`FDD_OFS_SPECIAL, 32'h1E);
    wr(`FDD_OFS_SPECIAL, 32'h1C);
    rd(ST, 32'h4, 32'h4);
    wr(FA, 32'h0007FFFF);
    rd(FA, 1 << `FDD_F_FWUP, 1 << `FDD_F_FWUP);
    @(posedge CLK_I);
    fws <= 0;
    RSTN_I <= 0;
    repeat (2) @(posedge CLK_I);
    RSTN_I <= 1;
    rd(FA, 1 << `FDD_F_FWUP, 0);
    repeat (4) @(posedge CLK_I);
    check(qm.size() + qr.size(), 0);
    complete_run;
  end
endmodule
